//--- include/lmb_consts.vh
// constants for the lookup, logic and math blocks: map, fields, resets, timing
// assumes word addressing on the register port, 32-bit signed data words
`ifndef LMB_CONSTS_VH
`define LMB_CONSTS_VH
`define LMB_CLK_NS      4
`define LMB_TICK_US     1000
`define LMB_TICK_CYC    (`LMB_TICK_US * 1000 / `LMB_CLK_NS)
`define LMB_NPT         11
`define LMB_NSRC        16
`define LMB_AREA_PL     3'h3
`define LMB_AREA_M0     3'h4
`define LMB_LUT_CTRL    5'h00
`define LMB_LUT_X0      5'h01
`define LMB_LUT_Y0      5'h0C
`define LMB_LUT_RESP    5'h17
`define LMB_STAT_LO     5'h18
`define LMB_PL_EN       5'h00
`define LMB_PL_SLOT0    5'h01
`define LMB_M_OPS       5'h0F
`define LMB_M_OMIN      5'h10
`define LMB_M_OMAX      5'h11
`define LMB_F_XTYPE     0
`define LMB_F_AUTO      1
`define LMB_F_XSRC      4
`define LMB_F_SCALER    16
`define LMB_RESP_IGN    2'h0
`define LMB_RESP_STEP   2'h2
`define LMB_SRC_IN0     4'h1
`define LMB_SRC_OTH0    4'h5
`define LMB_SRC_MATH0   4'h9
`define LMB_LOP_DEF     3'h0
`define LMB_LOP_ALL     3'h1
`define LMB_LOP_ANY     3'h2
`define LMB_LOP_AO      3'h3
`define LMB_LOP_OA      3'h4
`define LMB_FULL        32'sh000F4240
`define LMB_NORM        32'sh000003E8
`define LMB_OTHER_MAX   32'h000003E8
`define LMB_WEIGHT_ONE  12'h3E8
`define LMB_IN_MIN_RST  32'hFFFFFC18
`define LMB_OUT_MIN_RST 32'hFFF0BDC0
`define LMB_TURN        32'sh00000FA0
`define LMB_HALF        32'sh000007D0
`define LMB_TIME_MAX    32'h7FFFFFFF
`endif

//--- hw/lmb_lut.v
// one lookup table of eleven points, evaluated combinationally
// assumes the caller registers the result on the update tick
`timescale 1ns/1ps
`include "lmb_consts.vh"
module lmb_lut (
  // axis value and points
  input  wire [31:0]  x_i,
  input  wire [351:0] xs_i,
  input  wire [351:0] ys_i,
  input  wire [21:0]  resp_i,
  // results
  output reg  [31:0]  y_o,
  output reg  [31:0]  ymin_o,
  output reg  [31:0]  ymax_o,
  output reg  [31:0]  xlast_o
);
  function signed [31:0] pt;
    input [351:0] flat;
    input integer idx;
    begin
      pt = $signed(flat[32*idx +: 32]);
    end
  endfunction

  integer i, n, k;
  reg stop;
  reg signed [63:0] num;
  reg signed [63:0] dx;
  reg signed [63:0] yy;

  always @* begin
    n = 1;
    stop = 1'b0;
    // first ignored point cuts the rest away
    for (i = 1; i < `LMB_NPT; i = i + 1) begin
      if (!stop && resp_i[2*i +: 2] != `LMB_RESP_IGN) n = i + 1;
      else stop = 1'b1;
    end
    ymin_o = ys_i[31:0];
    ymax_o = ys_i[31:0];
    for (i = 1; i < `LMB_NPT; i = i + 1) begin
      if (i < n && pt(ys_i, i) < $signed(ymin_o)) ymin_o = ys_i[32*i +: 32];
      if (i < n && pt(ys_i, i) > $signed(ymax_o)) ymax_o = ys_i[32*i +: 32];
    end
    xlast_o = xs_i[32*(n-1) +: 32];
    k = 0;
    for (i = 1; i < `LMB_NPT; i = i + 1)
      if (i < n && $signed(x_i) > pt(xs_i, i - 1)) k = i;
    num = 64'sh0;
    dx = 64'sh0;
    yy = 64'sh0;
    // point zero always behaves as a step
    if (k == 0) begin
      y_o = ys_i[31:0];
    end else if ($signed(x_i) > pt(xs_i, k) || resp_i[2*k +: 2] == `LMB_RESP_STEP) begin
      y_o = ys_i[32*k +: 32];
    end else begin
      dx = pt(xs_i, k) - pt(xs_i, k - 1);
      num = (pt(ys_i, k) - pt(ys_i, k - 1)) * ($signed(x_i) - pt(xs_i, k - 1));
      yy = (dx == 64'sh0) ? pt(ys_i, k) : pt(ys_i, k - 1) + num / dx;
      y_o = yy[31:0];
    end
  end
endmodule

//--- hw/lmb_math.v
// one math block: five scaled inputs through four chained stages
// assumes raw values, ranges and weights stay steady over a tick
`timescale 1ns/1ps
`include "lmb_consts.vh"
module lmb_math (
  // inputs and their scaling
  input  wire [159:0] raw_i,
  input  wire [4:0]   used_i,
  input  wire [159:0] min_i,
  input  wire [159:0] max_i,
  input  wire [59:0]  wt_i,
  // stage operators and output range
  input  wire [19:0]  ops_i,
  input  wire [31:0]  omin_i,
  input  wire [31:0]  omax_i,
  output reg  [31:0]  y_o
);
  function signed [31:0] sat;
    input signed [63:0] v;
    begin
      if (v > `LMB_FULL) sat = `LMB_FULL;
      else if (v < -`LMB_FULL) sat = -`LMB_FULL;
      else sat = v[31:0];
    end
  endfunction

  function [31:0] isqrt;
    input [31:0] v;
    reg [31:0] r, b, rem;
    integer i;
    begin
      r = 32'h0;
      rem = v;
      b = 32'h40000000;
      for (i = 0; i < 16; i = i + 1) begin
        if (rem >= r + b) begin
          rem = rem - r - b;
          r = (r >> 1) + b;
        end else begin
          r = r >> 1;
        end
        b = b >> 2;
      end
      isqrt = r;
    end
  endfunction

  // sine in thousandths, a full turn is 4000 counts
  function signed [31:0] sinm;
    input signed [31:0] b;
    reg signed [31:0] r;
    begin
      r = b % `LMB_TURN;
      if (r < 0) r = r + `LMB_TURN;
      if (r < `LMB_HALF) sinm = r * (`LMB_HALF - r) / `LMB_NORM;
      else sinm = -((r - `LMB_HALF) * (`LMB_TURN - r) / `LMB_NORM);
    end
  endfunction

  function signed [31:0] stage;
    input [4:0] op;
    input signed [31:0] a, b;
    reg ta, tb;
    reg signed [63:0] w;
    begin
      ta = (a >= 1);
      tb = (b >= 1);
      case (op)
        5'h00: w = {63'h0, a == b};
        5'h01: w = {63'h0, a != b};
        5'h02: w = {63'h0, a > b};
        5'h03: w = {63'h0, a >= b};
        5'h04: w = {63'h0, a < b};
        5'h05: w = {63'h0, a <= b};
        5'h06: w = {63'h0, ta | tb};
        5'h07: w = {63'h0, ta & tb};
        5'h08: w = {63'h0, ta ^ tb};
        5'h09: w = a + b;
        5'h0A: w = a - b;
        5'h0B: w = a * b;
        5'h0C: w = (b == 0) ? `LMB_FULL : a / b;
        5'h0D: w = (a < b) ? a : b;
        5'h0E: w = (a > b) ? a : b;
        5'h0F: w = (a > b) ? a - b : b - a;
        5'h10: w = a * sinm(b) / `LMB_NORM;
        5'h11: w = a * sinm(b + `LMB_NORM) / `LMB_NORM;
        5'h12: w = (b < 0) ? 64'sh0 : a * $signed({1'b0, isqrt(b)});
        default: w = a;
      endcase
      stage = sat(w);
    end
  endfunction

  // map raw onto -1000..1000, then apply the weight
  function signed [31:0] scale;
    input signed [31:0] v, mn, mx;
    input signed [11:0] wt;
    reg signed [63:0] d, n;
    begin
      d = mx - mn;
      n = (d == 64'sh0) ? 64'sh0 : ((v - mn) * 2 * `LMB_NORM) / d - `LMB_NORM;
      if (n > `LMB_NORM) n = `LMB_NORM;
      if (n < -`LMB_NORM) n = -`LMB_NORM;
      n = n * wt / `LMB_NORM;
      scale = n[31:0];
    end
  endfunction

  integer s;
  reg signed [31:0] a;
  reg signed [31:0] bv;
  reg signed [63:0] o;

  always @* begin
    a = used_i[0] ? scale(raw_i[31:0], min_i[31:0], max_i[31:0], wt_i[11:0]) : 32'sh0;
    bv = 32'sh0;
    // each stage result is input A of the next; unused B passes A
    for (s = 1; s < 5; s = s + 1) begin
      bv = scale(raw_i[32*s +: 32], min_i[32*s +: 32], max_i[32*s +: 32], wt_i[12*s +: 12]);
      if (used_i[s]) a = stage(ops_i[5*(s-1) +: 5], a, bv);
    end
    o = $signed(omin_i) + ((a + `LMB_FULL) * ($signed(omax_i) - $signed(omin_i)))
        / (2 * `LMB_FULL);
    y_o = o[31:0];
  end
endmodule

//--- hw/lmb_top.v
// three lookup tables, a programmable logic selector and four math blocks
// assumes a register master as described and source values from other blocks
`timescale 1ns/1ps
`include "lmb_consts.vh"
// Functional notes
// - ten segments per table, three tables combined
// - axis type selects data or time response
// - point response ignore, ramp or step; point0 step
// - step segment outputs its end Y value
// - ignored point drops itself and later points
// - autocycle repeats time output while enabled
// - axis limits from source range, else 0..1000
// - X points kept non-decreasing within limits
// - output range is min and max valid Y
// - logic output only when enabled; resets disabled
// - conditions compare two arguments, six operators
// - unused argument source reads as zero
// - slot combines three conditions by code
// - first satisfied slot wins, else slot 0
// - four math blocks, five inputs each
// - inputs normalised to +-1000 then weighted
// - four chained stages; unused B passes A
// - stage operator codes 0 to 18
// - boolean true at one or more, 0/1 results
// - divide by zero and saturation at 1e6
// - output mapped by output min and max
module lmb_top #(
  parameter TICK_CYC = `LMB_TICK_CYC
) (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         rst_i,
  // register port
  input  wire [7:0]   addr_i,
  input  wire [31:0]  wdata_i,
  input  wire         wr_i,
  input  wire         rd_i,
  output reg  [31:0]  rdata_o,
  // source signals: four input blocks, four other blocks
  input  wire [255:0] sig_val_i,
  input  wire [127:0] in_min_i,
  input  wire [127:0] in_max_i,
  // block outputs
  output reg  [95:0]  lut_y_o,
  output reg  [31:0]  plog_y_o,
  output reg          plog_en_o,
  output reg  [1:0]   plog_slot_o,
  output reg  [127:0] math_y_o,
  output reg          upd_o
);
  localparam [31:0] TICK_LAST = TICK_CYC - 1;

  function [7:0] wa;
    input integer area;
    input integer off;
    begin
      wa = {area[2:0], off[4:0]};
    end
  endfunction

  function [31:0] sel;
    input [511:0] flat;
    input [3:0] code;
    begin
      sel = flat[32*code +: 32];
    end
  endfunction

  function cmp;
    input [2:0] op;
    input [31:0] a, b;
    begin
      case (op)
        3'h0: cmp = ($signed(a) == $signed(b));
        3'h1: cmp = ($signed(a) != $signed(b));
        3'h2: cmp = ($signed(a) > $signed(b));
        3'h3: cmp = ($signed(a) >= $signed(b));
        3'h4: cmp = ($signed(a) < $signed(b));
        3'h5: cmp = ($signed(a) <= $signed(b));
        default: cmp = 1'b0;
      endcase
    end
  endfunction

  function [31:0] rst_val;
    input integer idx;
    reg [4:0] off;
    begin
      off = idx[4:0];
      rst_val = 32'h0;
      if (idx[7:5] >= `LMB_AREA_M0) begin
        if (off < `LMB_M_OPS && off % 3 == 0)
          rst_val = {4'h0, `LMB_WEIGHT_ONE, 16'h0};
        else if (off < `LMB_M_OPS && off % 3 == 1)
          rst_val = `LMB_IN_MIN_RST;
        else if (off < `LMB_M_OPS)
          rst_val = `LMB_NORM;
        else if (off == `LMB_M_OMIN)
          rst_val = `LMB_OUT_MIN_RST;
        else if (off == `LMB_M_OMAX)
          rst_val = `LMB_FULL;
      end
    end
  endfunction

  reg  [31:0]   cfg [0:255];
  reg  [31:0]   tick_cnt;
  reg  [95:0]   el;
  reg  [511:0]  src_v;
  reg  [511:0]  src_lo;
  reg  [511:0]  src_hi;
  reg  [95:0]   lut_x;
  reg  [2:0]    lut_en;
  reg  [2:0]    lut_auto;
  reg  [1055:0] lut_xs;
  reg  [1055:0] lut_ys;
  reg  [65:0]   lut_rs;
  wire [95:0]   lut_y;
  wire [95:0]   lut_mn;
  wire [95:0]   lut_mx;
  wire [95:0]   lut_xl;
  reg  [639:0]  m_raw;
  reg  [639:0]  m_min;
  reg  [639:0]  m_max;
  reg  [19:0]   m_used;
  reg  [239:0]  m_wt;
  reg  [79:0]   m_ops;
  reg  [127:0]  m_omin;
  reg  [127:0]  m_omax;
  wire [127:0]  m_y;
  reg           pl_en;
  reg           pl_found;
  reg           pl_hit;
  reg  [2:0]    pl_c;
  reg  [1:0]    pl_slot;
  reg  [1:0]    pl_tbl;
  reg  [31:0]   pl_wa;
  reg  [31:0]   pl_wb;
  reg  [31:0]   pl_y;
  reg  [31:0]   wval;
  reg  [31:0]   x_lo;
  reg  [31:0]   x_hi;
  reg  [31:0]   rv;
  reg  [31:0]   ctrl;
  reg  [31:0]   wctl;
  wire          tick = (tick_cnt == TICK_LAST);
  integer i, ti, tj, si, sj, mi, mj, ri, ei;

  // source table: code 0 unused, 1-4 inputs, 5-8 others, 9-12 math
  always @* begin
    src_v = 512'h0;
    src_lo = 512'h0;
    for (i = 0; i < `LMB_NSRC; i = i + 1)
      src_hi[32*i +: 32] = `LMB_OTHER_MAX;
    for (i = 0; i < 4; i = i + 1) begin
      src_v[32*(i+`LMB_SRC_IN0) +: 32] = sig_val_i[32*i +: 32];
      src_lo[32*(i+`LMB_SRC_IN0) +: 32] = in_min_i[32*i +: 32];
      src_hi[32*(i+`LMB_SRC_IN0) +: 32] = in_max_i[32*i +: 32];
      src_v[32*(i+`LMB_SRC_OTH0) +: 32] = sig_val_i[32*(i+4) +: 32];
      src_v[32*(i+`LMB_SRC_MATH0) +: 32] = math_y_o[32*i +: 32];
      src_lo[32*(i+`LMB_SRC_MATH0) +: 32] = cfg[wa(`LMB_AREA_M0 + i, `LMB_M_OMIN)];
      src_hi[32*(i+`LMB_SRC_MATH0) +: 32] = cfg[wa(`LMB_AREA_M0 + i, `LMB_M_OMAX)];
    end
  end

  // table inputs: data value or elapsed milliseconds
  always @* begin
    ctrl = 32'h0;
    for (ti = 0; ti < 3; ti = ti + 1) begin
      ctrl = cfg[wa(ti, `LMB_LUT_CTRL)];
      lut_en[ti] = ($signed(sel(src_v, ctrl[`LMB_F_XSRC +: 4])) >= 1);
      lut_auto[ti] = ctrl[`LMB_F_AUTO];
      lut_x[32*ti +: 32] = ctrl[`LMB_F_XTYPE] ? el[32*ti +: 32]
                                              : sel(src_v, ctrl[`LMB_F_XSRC +: 4]);
      lut_rs[22*ti +: 22] = cfg[wa(ti, `LMB_LUT_RESP)][21:0];
      for (tj = 0; tj < `LMB_NPT; tj = tj + 1) begin
        lut_xs[352*ti + 32*tj +: 32] = cfg[wa(ti, `LMB_LUT_X0 + tj)];
        lut_ys[352*ti + 32*tj +: 32] = cfg[wa(ti, `LMB_LUT_Y0 + tj)];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_lut
      lmb_lut u_lut (
        .x_i     (lut_x[32*g +: 32]),
        .xs_i    (lut_xs[352*g +: 352]),
        .ys_i    (lut_ys[352*g +: 352]),
        .resp_i  (lut_rs[22*g +: 22]),
        .y_o     (lut_y[32*g +: 32]),
        .ymin_o  (lut_mn[32*g +: 32]),
        .ymax_o  (lut_mx[32*g +: 32]),
        .xlast_o (lut_xl[32*g +: 32])
      );
    end
  endgenerate

  // selector: ordered slots of three conditions each
  always @* begin
    pl_en = cfg[wa(`LMB_AREA_PL, `LMB_PL_EN)][0];
    pl_found = 1'b0;
    pl_hit = 1'b0;
    pl_slot = 2'h0;
    pl_c = 3'h0;
    pl_wa = 32'h0;
    pl_wb = 32'h0;
    for (si = 0; si < 3; si = si + 1) begin
      pl_wa = cfg[wa(`LMB_AREA_PL, `LMB_PL_SLOT0 + 2 * si)];
      pl_wb = cfg[wa(`LMB_AREA_PL, `LMB_PL_SLOT0 + 2 * si + 1)];
      for (sj = 0; sj < 3; sj = sj + 1)
        pl_c[sj] = cmp(pl_wa[8+4*sj +: 3], sel(src_v, pl_wb[8*sj +: 4]),
                       sel(src_v, pl_wb[8*sj+4 +: 4]));
      case (pl_wa[6:4])
        `LMB_LOP_DEF: pl_hit = 1'b1;
        `LMB_LOP_ALL: pl_hit = &pl_c;
        `LMB_LOP_ANY: pl_hit = |pl_c;
        `LMB_LOP_AO:  pl_hit = (pl_c[0] & pl_c[1]) | pl_c[2];
        `LMB_LOP_OA:  pl_hit = (pl_c[0] | pl_c[1]) & pl_c[2];
        default:      pl_hit = 1'b0;
      endcase
      if (pl_hit && !pl_found) begin
        pl_found = 1'b1;
        pl_slot = si[1:0];
      end
    end
    pl_wa = cfg[wa(`LMB_AREA_PL, `LMB_PL_SLOT0 + 2 * pl_slot)];
    pl_tbl = (pl_wa[1:0] == 2'h3) ? 2'h0 : pl_wa[1:0];
    pl_y = pl_en ? lut_y[32*pl_tbl +: 32] : 32'h0;
  end

  // math inputs: word 3y source and weight, 3y+1 min, 3y+2 max
  always @* begin
    for (mi = 0; mi < 4; mi = mi + 1) begin
      for (mj = 0; mj < 5; mj = mj + 1) begin
        m_raw[160*mi + 32*mj +: 32] = sel(src_v, cfg[wa(`LMB_AREA_M0 + mi, 3 * mj)][3:0]);
        m_used[5*mi + mj] = (cfg[wa(`LMB_AREA_M0 + mi, 3 * mj)][3:0] != 4'h0);
        m_wt[60*mi + 12*mj +: 12] = cfg[wa(`LMB_AREA_M0 + mi, 3 * mj)][`LMB_F_SCALER +: 12];
        m_min[160*mi + 32*mj +: 32] = cfg[wa(`LMB_AREA_M0 + mi, 3 * mj + 1)];
        m_max[160*mi + 32*mj +: 32] = cfg[wa(`LMB_AREA_M0 + mi, 3 * mj + 2)];
      end
      m_ops[20*mi +: 20] = cfg[wa(`LMB_AREA_M0 + mi, `LMB_M_OPS)][19:0];
      m_omin[32*mi +: 32] = cfg[wa(`LMB_AREA_M0 + mi, `LMB_M_OMIN)];
      m_omax[32*mi +: 32] = cfg[wa(`LMB_AREA_M0 + mi, `LMB_M_OMAX)];
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_math
      lmb_math u_math (
        .raw_i  (m_raw[160*g +: 160]),
        .used_i (m_used[5*g +: 5]),
        .min_i  (m_min[160*g +: 160]),
        .max_i  (m_max[160*g +: 160]),
        .wt_i   (m_wt[60*g +: 60]),
        .ops_i  (m_ops[20*g +: 20]),
        .omin_i (m_omin[32*g +: 32]),
        .omax_i (m_omax[32*g +: 32]),
        .y_o    (m_y[32*g +: 32])
      );
    end
  endgenerate

  // write value: X points clamped between neighbours and axis limits
  always @* begin
    wval = wdata_i;
    wctl = 32'h0;
    x_lo = 32'h0;
    x_hi = `LMB_TIME_MAX;
    if (addr_i[7:5] < `LMB_AREA_PL && addr_i[4:0] >= `LMB_LUT_X0 &&
        addr_i[4:0] < `LMB_LUT_Y0) begin
      wctl = cfg[{addr_i[7:5], `LMB_LUT_CTRL}];
      if (!wctl[`LMB_F_XTYPE]) begin
        x_lo = sel(src_lo, wctl[`LMB_F_XSRC +: 4]);
        x_hi = sel(src_hi, wctl[`LMB_F_XSRC +: 4]);
      end
      if (addr_i[4:0] != `LMB_LUT_X0) x_lo = cfg[addr_i - 8'h01];
      if (addr_i[4:0] != `LMB_LUT_Y0 - 5'h01) x_hi = cfg[addr_i + 8'h01];
      if ($signed(wval) > $signed(x_hi)) wval = x_hi;
      if ($signed(wval) < $signed(x_lo)) wval = x_lo;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (ri = 0; ri < 256; ri = ri + 1)
        cfg[ri] <= rst_val(ri);
    end else if (wr_i && addr_i[4:0] < `LMB_STAT_LO) begin
      cfg[addr_i] <= wval;
    end
  end

  // update tick and elapsed time per table
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0;
      el <= 96'h0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      for (ei = 0; ei < 3; ei = ei + 1) begin
        if (tick) begin
          if (!lut_en[ei])
            el[32*ei +: 32] <= 32'h0;
          else if (el[32*ei +: 32] >= lut_xl[32*ei +: 32])
            el[32*ei +: 32] <= lut_auto[ei] ? 32'h0 : el[32*ei +: 32];
          else
            el[32*ei +: 32] <= el[32*ei +: 32] + 32'h1;
        end
      end
    end
  end

  // registered block outputs
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lut_y_o <= 96'h0;
      plog_y_o <= 32'h0;
      plog_en_o <= 1'b0;
      plog_slot_o <= 2'h0;
      math_y_o <= 128'h0;
      upd_o <= 1'b0;
    end else begin
      upd_o <= tick;
      if (tick) begin
        lut_y_o <= lut_y;
        plog_y_o <= pl_y;
        plog_en_o <= pl_en;
        plog_slot_o <= pl_slot;
        math_y_o <= m_y;
      end
    end
  end

  // read data: config words, or block state in the upper offsets
  always @* begin
    rv = 32'h0;
    if (addr_i[4:0] < `LMB_STAT_LO)
      rv = cfg[addr_i];
    else if (addr_i[7:5] < `LMB_AREA_PL) begin
      if (addr_i[2:0] == 3'h0) rv = lut_y_o[32*addr_i[6:5] +: 32];
      if (addr_i[2:0] == 3'h1) rv = lut_mn[32*addr_i[6:5] +: 32];
      if (addr_i[2:0] == 3'h2) rv = lut_mx[32*addr_i[6:5] +: 32];
    end else if (addr_i[7:5] == `LMB_AREA_PL) begin
      if (addr_i[2:0] == 3'h0) rv = plog_y_o;
      if (addr_i[2:0] == 3'h1) rv = {29'h0, plog_en_o, plog_slot_o};
    end else if (addr_i[2:0] == 3'h0)
      rv = math_y_o[32*(addr_i[7:5] - `LMB_AREA_M0) +: 32];
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i)
      rdata_o <= 32'h0;
    else
      rdata_o <= rd_i ? rv : 32'h0;
  end
endmodule

//--- verif/lmb_src_model.sv
// partner: source blocks that feed the tables, selector and math blocks
// assumes the bench sets values through put, right after a clock edge
`timescale 1ns/1ps
module lmb_src_model (
  input  wire         clk_i,
  output reg  [255:0] sig_val_o,
  output wire [127:0] in_min_o,
  output wire [127:0] in_max_o
);
  // input blocks span 0..1000
  assign in_min_o = {4{32'h00000000}};
  assign in_max_o = {4{32'h000003E8}};
  initial sig_val_o = 256'h0;
  task put(input int idx, input int val);
    @(posedge clk_i);
    sig_val_o[idx * 32 +: 32] <= val;
  endtask
endmodule

//--- verif/lmb_top_properties.sv
// checker: port-level timing of the table, selector and math outputs
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/1ps
module lmb_top_chk #(
  parameter TICK_CYC = 20
) (
  input wire         ref_clk_i,
  input wire         rst_i,
  input wire [7:0]   addr_i,
  input wire         rd_i,
  input wire [31:0]  rdata_o,
  input wire [95:0]  lut_y_o,
  input wire [31:0]  plog_y_o,
  input wire         plog_en_o,
  input wire [1:0]   plog_slot_o,
  input wire [127:0] math_y_o,
  input wire         upd_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  reg [31:0] gap;
  reg        seen;
  // cycles since the last update pulse
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap  <= 32'h0;
      seen <= 1'b0;
    end else if (upd_o) begin
      gap  <= 32'h0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h1;
    end
  end
  sequence s_rd_at(a);
    rd_i && addr_i == a;
  endsequence
  sequence s_pulse;
    upd_o ##1 !upd_o;
  endsequence
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_upd_pulse; upd_o |-> s_pulse; endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
  property p_upd_period; upd_o && seen |-> gap == TICK_CYC - 1; endproperty
  a_upd_period: assert property (p_upd_period) else $error("update period wrong");
  property p_out_hold;
    !upd_o |-> $stable(lut_y_o) && $stable(math_y_o) && $stable(plog_y_o)
      && $stable(plog_slot_o);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved off tick");
  property p_plog_off; !plog_en_o |-> plog_y_o == 32'h0; endproperty
  a_plog_off: assert property (p_plog_off) else $error("disabled selector drives");
  property p_slot; plog_slot_o != 2'h3; endproperty
  a_slot: assert property (p_slot) else $error("slot out of range");
  property p_en_rst; $past(rst_i) |-> !plog_en_o; endproperty
  a_en_rst: assert property (p_en_rst) else $error("selector enabled at reset");
  property p_lut_rd; s_rd_at(8'h18) |=> rdata_o == $past(lut_y_o[31:0]); endproperty
  a_lut_rd: assert property (p_lut_rd) else $error("table status mismatch");
  property p_math_rd; s_rd_at(8'h98) |=> rdata_o == $past(math_y_o[31:0]); endproperty
  a_math_rd: assert property (p_math_rd) else $error("math status mismatch");
endmodule
bind lmb_top lmb_top_chk #(.TICK_CYC(TICK_CYC)) i_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .lut_y_o(lut_y_o), .plog_y_o(plog_y_o), .plog_en_o(plog_en_o),
  .plog_slot_o(plog_slot_o), .math_y_o(math_y_o), .upd_o(upd_o));

//--- verif/lmb_top_test.sv
// bench: tables, selector and math blocks fed by the source model
// assumes a 20-cycle update tick and the register map of the design
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module lmb_top_test;
  localparam TICK = 20;
  reg          ref_clk_i = 0;
  reg          rst_i = 1;
  reg          wr_i = 0;
  reg          rd_i = 0;
  reg  [7:0]   addr_i = 8'h00;
  reg  [31:0]  wdata_i = 32'h0;
  reg  [31:0]  d;
  wire [31:0]  rdata_o, plog_y_o;
  wire [255:0] sig;
  wire [127:0] imin, imax, math_y_o;
  wire [95:0]  lut_y_o;
  wire [1:0]   plog_slot_o;
  wire         plog_en_o, upd_o;
  int          error_cnt = 0, checks_done = 0, i, k, s, x, y, c, cb, op, sa, sb, w1, w2;
  int          v[3];
  bit [2:0]    cr;
  int          ra[7] = '{8'h60, 8'h86, 8'h87, 8'h88, 8'h90, 8'h91, 8'h7C};
  int          rv[7] = '{0, 32'h03E80000, 32'hFFFFFC18, 32'h3E8, 32'hFFF0BDC0, 32'hF4240, 0};
  int          lr[5] = '{8, 8, 8, 4, 4};
  int          lx[5] = '{0, 300, 550, 250, 500};
  int          ly[5] = '{11, 77, 77, 44, 77};
  lmb_src_model i_src (.clk_i(ref_clk_i), .sig_val_o(sig), .in_min_o(imin), .in_max_o(imax));
  lmb_top #(.TICK_CYC(TICK)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sig_val_i(sig),
    .in_min_i(imin), .in_max_i(imax), .lut_y_o(lut_y_o), .plog_y_o(plog_y_o),
    .plog_en_o(plog_en_o), .plog_slot_o(plog_slot_o), .math_y_o(math_y_o), .upd_o(upd_o));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  task wr(input [7:0] a, input [31:0] val);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= val;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task wupd(input int n);
    repeat (n) begin
      k = 0;
      @(posedge ref_clk_i);
      while (upd_o !== 1'b1 && k < 99) begin
        @(posedge ref_clk_i);
        k++;
      end
      if (k >= 99) begin
        error_cnt++;
        report_and_stop;
      end
    end
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // expected stage result, saturated at full scale
  function int mexp(input int o, input int a, input int b);
    int r;
    case (o)
      0: r = a == b;
      1: r = a != b;
      2: r = a > b;
      3: r = a >= b;
      4: r = a < b;
      5: r = a <= b;
      6: r = (a >= 1) || (b >= 1);
      7: r = (a >= 1) && (b >= 1);
      8: r = (a >= 1) != (b >= 1);
      9: r = a + b;
      10: r = a - b;
      11: r = a * b;
      12: r = (b == 0) ? 1000000 : a / b;
      13: r = a < b ? a : b;
      14: r = a > b ? a : b;
      18: r = (b < 0) ? 0 : a * int'($floor($sqrt(b)));
      default: r = a > b ? a - b : b - a;
    endcase
    if (r > 1000000) r = 1000000;
    if (r < -1000000) r = -1000000;
    return r;
  endfunction
  initial begin
    i = $urandom(32'hB97C);
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 7; i++) begin
      rd(ra[i]);
      `CHK(d, rv[i])
    end
    // table 0 on an other-block source, data axis
    wr(8'h00, 32'h50);
    wr(8'h0B, 1500);
    rd(8'h0B);
    `CHK(d, 32'h3E8)
    for (k = 9; k > 2; k--) wr(8'h01 + k, 1000);
    wr(8'h03, 600);
    wr(8'h02, 900);
    rd(8'h02);
    `CHK(d, 32'h258)
    wr(8'h02, 500);
    wr(8'h01, 0);
    wr(8'h0C, 11);
    wr(8'h0D, 77);
    wr(8'h0E, 999);
    for (i = 0; i < 5; i++) begin
      wr(8'h17, lr[i]);
      i_src.put(4, lx[i]);
      wupd(2);
      `CHK(lut_y_o[31:0], ly[i])
    end
    rd(8'h18);
    `CHK(d, 32'h4D)
    rd(8'h19);
    `CHK(d, 32'hB)
    rd(8'h1A);
    `CHK(d, 32'h4D)
    // time axis, last point at 3 ticks
    wr(8'h02, 3);
    wr(8'h17, 8);
    i_src.put(4, 1);
    for (x = 0; x < 2; x++) begin
      wr(8'h00, x ? 32'h51 : 32'h53);
      wupd(6);
      s = 0;
      for (i = 0; i < 8; i++) begin
        wupd(1);
        s += lut_y_o[31:0] === 32'hB;
      end
      `CHK(s, x ? 0 : 2)
    end
    // selector: slot s picks table s
    wr(8'h60, 1);
    wr(8'h2C, 222);
    wr(8'h4C, 333);
    for (i = 0; i < 12; i++) begin
      for (k = 0; k < 3; k++) begin
        v[k] = $urandom % 3;
        i_src.put(4 + k, v[k]);
      end
      y = 0;
      for (s = 2; s >= 0; s--) begin
        cb = (i + s) % 5;
        w1 = s | (cb << 4);
        w2 = 0;
        for (c = 0; c < 3; c++) begin
          op = (i + s + c) % 6;
          sa = $urandom % 4;
          sb = $urandom % 4;
          w1 |= op << (8 + 4 * c);
          w2 |= ((sa ? sa + 4 : 0) << (8 * c)) | ((sb ? sb + 4 : 0) << (8 * c + 4));
          cr[c] = mexp(op, sa ? v[sa - 1] : 0, sb ? v[sb - 1] : 0) != 0;
        end
        if (cb == 0 || (cb == 1 && &cr) || (cb == 2 && |cr) ||
            (cb == 3 && ((cr[0] && cr[1]) || cr[2])) || (cb == 4 && (cr[0] || cr[1]) && cr[2]))
          y = s;
        wr(8'h61 + 2 * s, w1);
        wr(8'h62 + 2 * s, w2);
      end
      wupd(2);
      `CHK(plog_slot_o, y[1:0])
      `CHK(plog_en_o, 1'b1)
      if (y > 0) `CHK(plog_y_o, 111 * (y + 1))
    end
    wr(8'h60, 0);
    wupd(2);
    `CHK(plog_y_o, 32'h0)
    // math block 0: A1 from code 5, B1 from code 6, later stages pass
    wr(8'h80, 32'h03E80005);
    wr(8'h83, 32'h03E80006);
    for (i = 0; i < 33; i++) begin
      x = $urandom % 2001 - 1000;
      y = (i == 12) ? 0 : $urandom % 2001 - 1000;
      op = i % 17;
      if (op == 16) op = 18;
      wr(8'h8F, op);
      i_src.put(4, x);
      i_src.put(5, y);
      wupd(2);
      `CHK(math_y_o[31:0], mexp(op, x, y))
    end
    wr(8'h90, 0);
    wr(8'h91, 32'h001E8480);
    wupd(2);
    rd(8'h98);
    `CHK(d, mexp(15, x, y) + 1000000)
    report_and_stop;
  end
endmodule
